// File: iapu_pkg.sv
// constants and types of the indirect address pointer unit
package iapu_pkg;
   localparam int IAPU_NPTR = 3;
   localparam int IAPU_AW = 12;
   localparam logic [IAPU_AW-1:0] IAPU_PTR_RESET = 12'h000;
   // virtual operand addresses, per pair base, stride between pairs
   localparam logic [IAPU_AW-1:0] IAPU_PLAIN_BASE = 12'hfef;
   localparam logic [IAPU_AW-1:0] IAPU_PAIR_STRIDE = 12'h008;
   localparam logic [IAPU_AW-1:0] IAPU_POST_DECREMENT_OPERAND_OFS = 12'h001;
   localparam logic [IAPU_AW-1:0] IAPU_POST_INCREMENT_OPERAND_OFS = 12'h002;
   localparam logic [IAPU_AW-1:0] IAPU_PRE_INCREMENT_OPERAND_OFS = 12'h003;
   localparam logic [IAPU_AW-1:0] IAPU_OFFSET_INDIRECT_OPERAND_OFS = 12'h004;
   // pointer byte addresses: low byte base, high byte one above
   localparam logic [IAPU_AW-1:0] IAPU_PTRL_BASE = 12'hff4;
   localparam logic [IAPU_AW-1:0] IAPU_PTR_HI_OFS = 12'h001;
   localparam logic [7:0] IAPU_ZERO_BYTE = 8'h00;
   localparam logic [1:0] IAPU_PH_TWO = 2'h1;
   localparam logic [1:0] IAPU_PH_FOUR = 2'h3;
   typedef enum logic [2:0] {IAPU_OP_NONE, IAPU_OP_PLAIN, IAPU_OP_POST_DECREMENT_OPERAND, IAPU_OP_POST_INCREMENT_OPERAND,
      IAPU_OP_PRE_INCREMENT_OPERAND, IAPU_OP_OFFSET_INDIRECT_OPERAND} iapu_op_t;
   typedef enum {IAPU_PH1, IAPU_PH2, IAPU_PH3, IAPU_PH4} iapu_phase_t;
endpackage

// File: iapu_top.sv
// indirect address pointer unit: pointer pairs, virtual operands, phase sequencing
`timescale 1ns/1ns
`default_nettype none
module iapu_top
   import iapu_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic instr_start,
   input wire logic [IAPU_AW-1:0] src_addr,
   input wire logic src_rd,
   input wire logic [IAPU_AW-1:0] dst_addr,
   input wire logic dst_wr,
   input wire logic [7:0] result_data,
   input wire logic [7:0] working_reg,
   input wire logic [7:0] mem_rdata,
   output logic [7:0] operand_q,
   output logic operand_valid_q,
   output logic [IAPU_AW-1:0] mem_addr_q,
   output logic mem_rd_q,
   output logic mem_wr_q,
   output logic [7:0] mem_wdata_q,
   output logic [1:0] phase_q,
   output logic [IAPU_NPTR*16-1:0] pointer_pair_q
);
   // ---------------------------------------------
   // address decode
   // ---------------------------------------------
   function automatic iapu_op_t dec_op(input logic [IAPU_AW-1:0] a);
      iapu_op_t r;
      logic [IAPU_AW-1:0] b;
      r = IAPU_OP_NONE;
      for (int i = 0; i < IAPU_NPTR; i++) begin
         b = IAPU_PLAIN_BASE - IAPU_PAIR_STRIDE * IAPU_AW'(i);
         if (a == b) r = IAPU_OP_PLAIN;
         if (a == b + IAPU_POST_DECREMENT_OPERAND_OFS) r = IAPU_OP_POST_DECREMENT_OPERAND;
         if (a == b + IAPU_POST_INCREMENT_OPERAND_OFS) r = IAPU_OP_POST_INCREMENT_OPERAND;
         if (a == b + IAPU_PRE_INCREMENT_OPERAND_OFS) r = IAPU_OP_PRE_INCREMENT_OPERAND;
         if (a == b + IAPU_OFFSET_INDIRECT_OPERAND_OFS) r = IAPU_OP_OFFSET_INDIRECT_OPERAND;
      end
      return r;
   endfunction
   function automatic logic [1:0] dec_idx(input logic [IAPU_AW-1:0] a);
      logic [1:0] r;
      logic [IAPU_AW-1:0] b;
      r = 2'h0;
      for (int i = 0; i < IAPU_NPTR; i++) begin
         b = IAPU_PLAIN_BASE - IAPU_PAIR_STRIDE * IAPU_AW'(i);
         if (a >= b && a <= b + IAPU_OFFSET_INDIRECT_OPERAND_OFS) r = 2'(i);
      end
      return r;
   endfunction
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   iapu_phase_t ph_q, ph_d;
   logic [15:0] ptr_q [IAPU_NPTR];
   logic [15:0] ptr_d [IAPU_NPTR];
   logic upd_q, upd_d;
   logic [IAPU_AW-1:0] rd_ea_q, rd_ea_d, wr_ea_q, wr_ea_d;
   logic rd_virt_q, rd_virt_d, wr_virt_q, wr_virt_d;
   logic [7:0] opnd_d, wdata_d;
   logic opv_d, mrd_d, mwr_d;
   logic [IAPU_AW-1:0] maddr_d;
   iapu_op_t sop, dop;
   logic [1:0] sidx, didx;
   logic [15:0] sp, dp;
   logic [IAPU_AW-1:0] ea_s, ea_d;
   logic [15:0] wext;
   always_comb begin
      sop = dec_op(src_addr);
      dop = dec_op(dst_addr);
      sidx = dec_idx(src_addr);
      didx = dec_idx(dst_addr);
      sp = ptr_q[sidx];
      dp = ptr_q[didx];
      wext = {{8{working_reg[7]}}, working_reg};
      ea_s = src_addr;
      unique case (sop)
         IAPU_OP_NONE: ea_s = src_addr;
         IAPU_OP_PRE_INCREMENT_OPERAND: ea_s = IAPU_AW'(sp + 16'h0001);
         IAPU_OP_OFFSET_INDIRECT_OPERAND: ea_s = IAPU_AW'(sp + wext);
         default: ea_s = IAPU_AW'(sp);
      endcase
      ea_d = dst_addr;
      unique case (dop)
         IAPU_OP_NONE: ea_d = dst_addr;
         IAPU_OP_PRE_INCREMENT_OPERAND: ea_d = IAPU_AW'(dp + 16'h0001);
         IAPU_OP_OFFSET_INDIRECT_OPERAND: ea_d = IAPU_AW'(dp + wext);
         default: ea_d = IAPU_AW'(dp);
      endcase
   end
   // ---------------------------------------------
   // phase sequencing and accesses
   // ---------------------------------------------
   always_comb begin
      ph_d = ph_q;
      ptr_d = ptr_q;
      upd_d = upd_q;
      rd_ea_d = rd_ea_q;
      wr_ea_d = wr_ea_q;
      rd_virt_d = rd_virt_q;
      wr_virt_d = wr_virt_q;
      opnd_d = operand_q;
      opv_d = 1'b0;
      mrd_d = 1'b0;
      mwr_d = 1'b0;
      maddr_d = mem_addr_q;
      wdata_d = mem_wdata_q;
      unique case (ph_q)
         IAPU_PH1: begin
            if (instr_start) begin
               ph_d = IAPU_PH2;
               upd_d = 1'b0;
               rd_ea_d = ea_s;
               wr_ea_d = ea_d;
               rd_virt_d = sop != IAPU_OP_NONE && dec_op(ea_s) != IAPU_OP_NONE;
               wr_virt_d = dop != IAPU_OP_NONE && dec_op(ea_d) != IAPU_OP_NONE;
            end
         end
         IAPU_PH2: begin
            ph_d = IAPU_PH3;
            if (src_rd) begin
               mrd_d = !rd_virt_q;
               maddr_d = rd_ea_q;
            end
            // single pointer update per instruction, read operand first
            if (src_rd && sop inside {IAPU_OP_POST_DECREMENT_OPERAND, IAPU_OP_POST_INCREMENT_OPERAND, IAPU_OP_PRE_INCREMENT_OPERAND}) begin
               upd_d = 1'b1;
               ptr_d[sidx] = sop == IAPU_OP_POST_DECREMENT_OPERAND ? sp - 16'h0001 : sp + 16'h0001;
            end
         end
         IAPU_PH3: begin
            ph_d = IAPU_PH4;
            opnd_d = rd_virt_q ? IAPU_ZERO_BYTE : mem_rdata;
            opv_d = src_rd;
            // pointer byte read directly or through a pointer
            for (int i = 0; i < IAPU_NPTR; i++) begin
               if (rd_ea_q == IAPU_PTRL_BASE - IAPU_PAIR_STRIDE * IAPU_AW'(i))
                  opnd_d = ptr_q[i][7:0];
               if (rd_ea_q == IAPU_PTRL_BASE - IAPU_PAIR_STRIDE * IAPU_AW'(i) + IAPU_PTR_HI_OFS)
                  opnd_d = ptr_q[i][15:8];
            end
         end
         IAPU_PH4: begin
            ph_d = IAPU_PH1;
            if (dst_wr && !wr_virt_q) begin
               mwr_d = 1'b1;
               maddr_d = wr_ea_q;
               wdata_d = result_data;
               if (!upd_q && dop inside {IAPU_OP_POST_DECREMENT_OPERAND, IAPU_OP_POST_INCREMENT_OPERAND, IAPU_OP_PRE_INCREMENT_OPERAND})
                  ptr_d[didx] = dop == IAPU_OP_POST_DECREMENT_OPERAND ? dp - 16'h0001 : dp + 16'h0001;
               for (int i = 0; i < IAPU_NPTR; i++) begin
                  // write to a pointer byte stores the value, no modify
                  if (wr_ea_q == IAPU_PTRL_BASE - IAPU_PAIR_STRIDE * IAPU_AW'(i))
                     ptr_d[i] = {ptr_q[i][15:8], result_data};
                  if (wr_ea_q == IAPU_PTRL_BASE - IAPU_PAIR_STRIDE * IAPU_AW'(i) + IAPU_PTR_HI_OFS)
                     ptr_d[i] = {result_data, ptr_q[i][7:0]};
               end
            end
         end
      endcase
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ph_q <= IAPU_PH1;
         for (int i = 0; i < IAPU_NPTR; i++) ptr_q[i] <= 16'(IAPU_PTR_RESET);
         upd_q <= 1'b0;
         rd_ea_q <= IAPU_PTR_RESET;
         wr_ea_q <= IAPU_PTR_RESET;
         rd_virt_q <= 1'b0;
         wr_virt_q <= 1'b0;
         operand_q <= IAPU_ZERO_BYTE;
         operand_valid_q <= 1'b0;
         mem_rd_q <= 1'b0;
         mem_wr_q <= 1'b0;
         mem_addr_q <= IAPU_PTR_RESET;
         mem_wdata_q <= IAPU_ZERO_BYTE;
      end else begin
         ph_q <= ph_d;
         ptr_q <= ptr_d;
         upd_q <= upd_d;
         rd_ea_q <= rd_ea_d;
         wr_ea_q <= wr_ea_d;
         rd_virt_q <= rd_virt_d;
         wr_virt_q <= wr_virt_d;
         operand_q <= opnd_d;
         operand_valid_q <= opv_d;
         mem_rd_q <= mrd_d;
         mem_wr_q <= mwr_d;
         mem_addr_q <= maddr_d;
         mem_wdata_q <= wdata_d;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) phase_q <= 2'h0;
      else phase_q <= 2'(ph_d);
   end
   generate
      for (genvar g = 0; g < IAPU_NPTR; g++) begin : g_out
         always_ff @(posedge sys_clk) begin
            if (!rst_n) pointer_pair_q[g*16 +: 16] <= 16'(IAPU_PTR_RESET);
            else pointer_pair_q[g*16 +: 16] <= ptr_d[g];
         end
      end
   endgenerate
   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   rd_in_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mem_rd_q |-> phase_q == IAPU_PH_TWO + 2'h1) else $error("read outside phase two");
   wr_in_four_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mem_wr_q |-> phase_q == 2'(IAPU_PH_FOUR + 2'h1)) else $error("write outside phase four");
   virt_rd_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ($past(rd_virt_q) && operand_valid_q) |-> operand_q == IAPU_ZERO_BYTE)
      else $error("virtual read not zero");
   virt_wr_none_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ph_q == IAPU_PH4 && wr_virt_q) |=> !mem_wr_q) else $error("virtual write reached memory");
   post_decrement_operand_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ph_q == IAPU_PH1 && instr_start && src_rd && sop == IAPU_OP_POST_DECREMENT_OPERAND) |=>
      ##1 ptr_q[$past(sidx, 2)] == $past(sp, 2) - 16'h0001) else $error("post decrement wrong");
   post_increment_operand_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ph_q == IAPU_PH1 && instr_start && src_rd && sop == IAPU_OP_POST_INCREMENT_OPERAND) |=>
      ##1 ptr_q[$past(sidx, 2)] == $past(sp, 2) + 16'h0001) else $error("post increment wrong");
   post_increment_operand_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ph_q == IAPU_PH1 && instr_start && sop == IAPU_OP_POST_INCREMENT_OPERAND) |=> rd_ea_q == IAPU_AW'($past(sp)))
      else $error("post increment address wrong");
   pre_increment_operand_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ph_q == IAPU_PH1 && instr_start && sop == IAPU_OP_PRE_INCREMENT_OPERAND) |=> rd_ea_q == IAPU_AW'($past(sp) + 16'h0001))
      else $error("pre increment address wrong");
   plain_keep_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (ph_q == IAPU_PH1 && instr_start && sop inside {IAPU_OP_PLAIN, IAPU_OP_OFFSET_INDIRECT_OPERAND} && !dst_wr) |=>
      ##2 ptr_q[$past(sidx, 3)] == $past(sp, 3)) else $error("pointer changed by plain access");
endmodule
`default_nettype wire

// File: iapu_mem_model.sv
// data memory model on the far side of the pointer unit
`timescale 1ns/1ns
`default_nettype none
module iapu_mem_model
   import iapu_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [IAPU_AW-1:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:4095];
   logic [7:0] last_q;
   logic hold_q;
   initial begin
      for (int a = 0; a < 4096; a++) begin
         mem[a] = 8'(a ^ (a >> 4));
      end
      last_q = 8'h5a;
      hold_q = 1'b0;
   end
   // data held one cycle past the strobe, then driven inverted
   assign mem_rdata = mem_rd ? mem[mem_addr] : (hold_q ? last_q : ~last_q);
   always @(posedge sys_clk) begin
      hold_q <= mem_rd;
      if (mem_rd) begin
         last_q <= mem[mem_addr];
      end
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
   end
endmodule
`default_nettype wire

// File: iapu_top_test.sv
// self-checking testbench of the indirect address pointer unit
`timescale 1ns/1ns
`default_nettype none
module iapu_top_test import iapu_pkg::*;;
   logic sys_clk, rst_n, instr_start, src_rd, dst_wr, operand_valid_q, mem_rd_q, mem_wr_q;
   logic [IAPU_AW-1:0] src_addr, dst_addr, mem_addr_q;
   logic [7:0] result_data, working_reg, mem_rdata, operand_q, mem_wdata_q;
   logic [1:0] phase_q, g_ph;
   logic [IAPU_NPTR*16-1:0] pointer_pair_q;
   logic [15:0] ptr [0:2];
   logic [7:0] ref_mem [0:4095];
   logic g_rd, g_ov, g_wr;
   logic [11:0] g_ra, g_wa;
   logic [7:0] g_op, g_wd;
   logic [15:0] p;
   int failures, n_compared;
   iapu_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .instr_start(instr_start), .src_addr(src_addr),
      .src_rd(src_rd), .dst_addr(dst_addr), .dst_wr(dst_wr), .result_data(result_data),
      .working_reg(working_reg), .mem_rdata(mem_rdata), .operand_q(operand_q),
      .operand_valid_q(operand_valid_q), .mem_addr_q(mem_addr_q), .mem_rd_q(mem_rd_q),
      .mem_wr_q(mem_wr_q), .mem_wdata_q(mem_wdata_q), .phase_q(phase_q), .pointer_pair_q(pointer_pair_q));
   iapu_mem_model mem_model (.sys_clk(sys_clk), .mem_addr(mem_addr_q), .mem_rd(mem_rd_q),
      .mem_wr(mem_wr_q), .mem_wdata(mem_wdata_q), .mem_rdata(mem_rdata));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // ---------------------------------------------------------------
   // bus tasks, checks and expectations
   // ---------------------------------------------------------------
   task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_ptrs();
      n_compared++;
      if (pointer_pair_q !== {ptr[2], ptr[1], ptr[0]}) begin
         failures++;
         $display("CHECK FAILED at %0t: pointers %h", $time, pointer_pair_q);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   function automatic logic [11:0] vaddr(input int n, input int k);
      return IAPU_PLAIN_BASE - 12'(8 * n) + 12'(k);
   endfunction
   function automatic logic [11:0] pb(input int n, input logic hi);
      return IAPU_PTRL_BASE - 12'(8 * n) + (hi ? IAPU_PTR_HI_OFS : 12'h000);
   endfunction
   function automatic logic [15:0] eff(input int k, input logic [15:0] a, input logic [7:0] w);
      return k == 3 ? a + 16'h0001 : (k == 4 ? a + {{8{w[7]}}, w} : a);
   endfunction
   function automatic logic [15:0] nxt(input int k, input logic [15:0] a);
      return k == 1 ? a - 16'h0001 : ((k == 2 || k == 3) ? a + 16'h0001 : a);
   endfunction
   // one instruction cycle, outputs taken at the phase they stand in
   task automatic instr(input logic [11:0] s, input logic r, input logic [11:0] d, input logic w,
      input logic [7:0] dat, input logic [7:0] wreg);
      src_addr = s;
      src_rd = r;
      dst_addr = d;
      dst_wr = w;
      result_data = dat;
      working_reg = wreg;
      instr_start = 1'b1;
      @(posedge sys_clk);
      #1 instr_start = 1'b0;
      g_ph = phase_q;
      @(posedge sys_clk);
      #1 {g_rd, g_ra} = {mem_rd_q, mem_addr_q};
      @(posedge sys_clk);
      #1 {g_ov, g_op} = {operand_valid_q, operand_q};
      @(posedge sys_clk);
      #1 {g_wr, g_wa, g_wd} = {mem_wr_q, mem_addr_q, mem_wdata_q};
   endtask
   task automatic set_ptr(input int n, input logic [15:0] v);
      instr(12'h000, 1'b0, pb(n, 1'b0), 1'b1, v[7:0], 8'h00);
      instr(12'h000, 1'b0, pb(n, 1'b1), 1'b1, v[15:8], 8'h00);
      ptr[n] = v;
      chk_ptrs();
      instr(pb(n, 1'b1), 1'b1, 12'h000, 1'b0, 8'h00, 8'h00);
      chk_val(24'(g_op), 24'(v[15:8]));
   endtask
   task automatic ind(input int n, input int k, input logic [15:0] a, input logic w, input logic [7:0] wreg);
      logic [15:0] ea;
      logic [7:0] d;
      ea = eff(k, a, wreg);
      d = 8'($urandom);
      set_ptr(n, a);
      instr(vaddr(n, k), 1'b1, vaddr(n, k), w, d, wreg);
      ptr[n] = nxt(k, a);
      chk_val(24'({g_rd, g_ra}), 24'({1'b1, ea[11:0]}));
      chk_val(24'(g_ph), 24'(IAPU_PH_TWO));
      chk_val(24'({g_ov, g_op}), 24'({1'b1, ref_mem[ea[11:0]]}));
      chk_ptrs();
      chk_val(24'({g_wr, w ? {g_wa, g_wd} : 20'h0}), 24'({w, w ? {ea[11:0], d} : 20'h0}));
      if (w) begin
         ref_mem[ea[11:0]] = d;
      end
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      instr_start = 1'b0;
      {src_addr, src_rd, dst_addr, dst_wr, result_data, working_reg} = '0;
      failures = 0;
      n_compared = 0;
      for (int i = 0; i < 3; i++) begin
         ptr[i] = 16'(IAPU_PTR_RESET);
      end
      for (int a = 0; a < 4096; a++) begin
         ref_mem[a] = 8'(a ^ (a >> 4));
      end
      void'($urandom(3));
      repeat (12) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      chk_ptrs();
      ind(0, 2, 16'h00ff, 1'b0, 8'h00);
      ind(1, 1, 16'h0300, 1'b1, 8'h00);
      ind(2, 3, 16'h0eff, 1'b0, 8'h00);
      ind(0, 4, 16'h0400, 1'b0, 8'h80);
      ind(1, 4, 16'h0400, 1'b1, 8'h7f);
      ind(2, 2, 16'h0500, 1'b1, 8'h00);
      ind(1, 0, 16'h0f80, 1'b1, 8'h00);
      // pointer aimed at a virtual operand register
      set_ptr(0, 16'h0fe7);
      instr(IAPU_PLAIN_BASE, 1'b1, IAPU_PLAIN_BASE, 1'b1, 8'h3c, 8'h00);
      chk_val(24'({g_rd, g_op}), 24'h0);
      chk_val(24'(g_wr), 24'h0);
      chk_ptrs();
      // write through a post-decrement operand into its own pair
      set_ptr(2, {4'h0, pb(2, 1'b0)});
      instr(12'h000, 1'b0, vaddr(2, 1), 1'b1, 8'h5a, 8'h00);
      ptr[2][7:0] = 8'h5a;
      chk_ptrs();
      for (int i = 0; i < 60; i++) begin
         p = 16'($urandom_range(16'h0eff, 16'h0100));
         if (i % 4 == 0) begin
            p[7:0] = 8'hff;
         end else if (i % 4 == 1) begin
            p[7:0] = 8'h00;
         end
         ind($urandom_range(2), $urandom_range(4), p, 1'(i % 2), 8'($urandom));
      end
      tally_and_finish();
   end
   initial begin
      #100000;
      failures++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
